// *** logic/emmi_top.sv ***
// Memory map decode, external memory bus and RAM clear sequencer
`timescale 1ns/1ns
`include "emmi_defs.svh"
module emmi_top import emmi_pkg::*; #(
  parameter int RAM_BYTES = `EMMI_RAM_BYTES,
  parameter int NV_WR_US  = `EMMI_NV_WR_US
) (
  input  wire logic        SYS_CLK,
  input  wire logic        NRST,
  input  wire logic        LOW_SUPPLY,
  input  wire logic        REQ_VALID,
  input  wire logic [1:0]  REQ_CPU,
  input  wire logic [15:0] REQ_ADDR,
  input  wire logic        REQ_WRITE,
  input  wire logic [7:0]  REQ_WDATA,
  output logic             REQ_READY,
  output logic             RSP_VALID,
  output logic [7:0]       RSP_RDATA,
  output logic [1:0]       SLOT_CPU,
  output logic             INIT_DONE,
  output logic [7:0]       BOOT_BYTE,
  input  wire logic        LOCK_WE,
  input  wire logic        LOCK_VAL,
  output logic             LOCK_STATE,
  input  wire logic [7:0]  ALLOC_LEN,
  output logic [8:0]       ALLOC_ROUND,
  output logic [15:0]      EXT_ADDR_LINES,
  input  wire logic [7:0]  EXT_DATA_LINES_I,
  output logic [7:0]       EXT_DATA_LINES_O,
  output logic             EXT_DATA_LINES_OE,
  output logic             EXT_E_N,
  output logic             EXT_RW
);
  localparam logic [10:0] RAM_LAST = 11'(RAM_BYTES - 1);

  emmi_state_t st_ff;
  emmi_state_t nxt_st;
  emmi_tgt_t   tgt;
  emmi_tgt_t   tgt_ff;
  logic        rst_act;
  logic        e_n_ff;
  logic [1:0]  slot_ff;
  logic        take;
  logic        done_acc;
  logic        ready_ff;
  logic [10:0] clr_ff;
  logic [7:0]  ram_ff [RAM_BYTES];
  logic [7:0]  ram_q_ff;
  logic [15:0] addr_ff;
  logic        rw_ff;
  logic [7:0]  dout_ff;
  logic        doe_ff;
  logic        rsp_v_ff;
  logic [7:0]  rsp_d_ff;
  logic        init_ff;
  logic [7:0]  boot_ff;
  logic        nv_req_ff;
  logic        nv_we_ff;
  logic [8:0]  nv_addr_ff;
  logic [7:0]  nv_wd_ff;

  emmi_nv_if nv ();

  // Low supply forces the same reset as the pin
  assign rst_act = !NRST || LOW_SUPPLY;

  function automatic emmi_tgt_t tgt_of(input logic [15:0] a);
    if (a < `EMMI_INT_BASE) begin
      tgt_of = TGT_EXT;
    end else if (a < `EMMI_NV_BASE) begin
      tgt_of = TGT_RAM;
    end else if (a < `EMMI_NV_END) begin
      tgt_of = TGT_NV;
    end else begin
      tgt_of = TGT_IO;
    end
  endfunction

  assign tgt      = tgt_of(REQ_ADDR);
  assign take     = (st_ff == ST_IDLE) && !e_n_ff && REQ_VALID
                    && (REQ_CPU == slot_ff);
  assign done_acc = (st_ff == ST_ACC) && !e_n_ff;

  //==========================================
  // Strobe and processor phase
  always_ff @(posedge SYS_CLK) begin
    if (rst_act) begin
      e_n_ff <= 1'b1;
    end else begin
      e_n_ff <= !e_n_ff;
    end
  end

  // One slot per strobe period (two SYS_CLK cycles); processors rotate
  always_ff @(posedge SYS_CLK) begin
    if (rst_act) begin
      slot_ff <= 2'h0;
    end else if (!e_n_ff) begin
      slot_ff <= (slot_ff == 2'(`EMMI_NCPU - 1)) ? 2'h0 : slot_ff + 2'h1;
    end
  end

  //==========================================
  // Sequencer
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_BOOT: begin
        if (!e_n_ff) nxt_st = ST_BACC;
      end
      ST_BACC: begin
        if (!e_n_ff) nxt_st = ST_CLEAR;
      end
      ST_CLEAR: begin
        if (clr_ff == RAM_LAST) nxt_st = ST_IDLE;
      end
      ST_IDLE: begin
        if (take) nxt_st = (tgt == TGT_NV && REQ_WRITE) ? ST_NVW : ST_ACC;
      end
      ST_ACC: begin
        if (!e_n_ff) nxt_st = ST_IDLE;
      end
      ST_NVW: begin
        if (nv.done) nxt_st = ST_IDLE;
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (rst_act) begin
      st_ff    <= ST_BOOT;
      ready_ff <= 1'b0;
      init_ff  <= 1'b0;
      clr_ff   <= 11'h000;
      tgt_ff   <= TGT_EXT;
    end else begin
      st_ff    <= nxt_st;
      ready_ff <= nxt_st == ST_IDLE;
      if (st_ff == ST_CLEAR) begin
        clr_ff <= clr_ff + 11'h001;
        if (clr_ff == RAM_LAST) init_ff <= 1'b1;
      end
      if (take) tgt_ff <= tgt;
    end
  end

  //==========================================
  // Internal RAM; contents survive reset, cleared by the sequencer
  always_ff @(posedge SYS_CLK) begin
    if (!rst_act && st_ff == ST_CLEAR) begin
      ram_ff[clr_ff] <= 8'h00;
    end else if (take && tgt == TGT_RAM && REQ_WRITE) begin
      ram_ff[REQ_ADDR[10:0]] <= REQ_WDATA;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (take && tgt == TGT_RAM) begin
      ram_q_ff <= ram_ff[REQ_ADDR[10:0]];
    end
  end

  //==========================================
  // External bus pins
  always_ff @(posedge SYS_CLK) begin
    if (rst_act) begin
      addr_ff <= `EMMI_RST_ADDR;
      rw_ff   <= 1'b0;
      dout_ff <= 8'h00;
      doe_ff  <= 1'b1;
    end else if (st_ff == ST_BOOT && !e_n_ff) begin
      addr_ff <= `EMMI_BOOT_ADDR;
      rw_ff   <= 1'b1;
      doe_ff  <= 1'b0;
    end else if (take && tgt == TGT_EXT) begin
      addr_ff <= REQ_ADDR;
      rw_ff   <= !REQ_WRITE;
      dout_ff <= REQ_WDATA;
      doe_ff  <= REQ_WRITE;
    end else if (done_acc && tgt_ff == TGT_EXT) begin
      // Bus turns to read so the next access sees no stray write
      rw_ff  <= 1'b1;
      doe_ff <= 1'b0;
    end
  end

  //==========================================
  // Answers and nonvolatile requests
  always_ff @(posedge SYS_CLK) begin
    if (rst_act) begin
      rsp_v_ff <= 1'b0;
      rsp_d_ff <= 8'h00;
      boot_ff  <= 8'h00;
    end else begin
      rsp_v_ff <= done_acc || (st_ff == ST_NVW && nv.done);
      if (st_ff == ST_BACC && !e_n_ff) boot_ff <= EXT_DATA_LINES_I;
      if (done_acc) begin
        case (tgt_ff)
          TGT_EXT: rsp_d_ff <= EXT_DATA_LINES_I;
          TGT_RAM: rsp_d_ff <= ram_q_ff;
          TGT_NV:  rsp_d_ff <= nv.rdata;
          default: rsp_d_ff <= 8'h00;
        endcase
      end else if (st_ff == ST_NVW && nv.done) begin
        rsp_d_ff <= 8'h00;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (rst_act) begin
      nv_req_ff  <= 1'b0;
      nv_we_ff   <= 1'b0;
      nv_addr_ff <= 9'h000;
      nv_wd_ff   <= 8'h00;
    end else begin
      nv_req_ff <= take && tgt == TGT_NV;
      if (take) begin
        nv_we_ff   <= REQ_WRITE;
        nv_addr_ff <= REQ_ADDR[8:0];
        nv_wd_ff   <= REQ_WDATA;
      end
    end
  end

  assign nv.req       = nv_req_ff;
  assign nv.we        = nv_we_ff;
  assign nv.addr      = nv_addr_ff;
  assign nv.wdata     = nv_wd_ff;
  assign nv.lock_we   = LOCK_WE;
  assign nv.lock_val  = LOCK_VAL;
  assign nv.alloc_len = ALLOC_LEN;

  emmi_nvs #(
    .WR_CYC (NV_WR_US * `EMMI_CLK_MHZ)
  ) u_nvs (
    .clk (SYS_CLK),
    .rst (rst_act),
    .nv  (nv)
  );

  assign REQ_READY         = ready_ff;
  assign RSP_VALID         = rsp_v_ff;
  assign RSP_RDATA         = rsp_d_ff;
  assign SLOT_CPU          = slot_ff;
  assign INIT_DONE         = init_ff;
  assign BOOT_BYTE         = boot_ff;
  assign LOCK_STATE        = nv.lock_state;
  assign ALLOC_ROUND       = nv.alloc_round;
  assign EXT_ADDR_LINES    = addr_ff;
  assign EXT_DATA_LINES_O  = dout_ff;
  assign EXT_DATA_LINES_OE = doe_ff;
  assign EXT_E_N           = e_n_ff;
  assign EXT_RW            = rw_ff;

  //==========================================
  // Checks
  sequence s_ext_take;
    take && tgt == TGT_EXT;
  endsequence

  sequence s_ext_strobe;
    EXT_E_N ##1 !EXT_E_N;
  endsequence

  property p_toggle;
    @(posedge SYS_CLK) disable iff (rst_act)
    !$past(rst_act) |-> EXT_E_N != $past(EXT_E_N);
  endproperty
  a_toggle: assert property (p_toggle) else $error("strobe did not toggle");

  property p_slot;
    @(posedge SYS_CLK) disable iff (rst_act)
    !e_n_ff |=> slot_ff == (($past(slot_ff) == 2'h2) ? 2'h0 : $past(slot_ff) + 2'h1);
  endproperty
  a_slot: assert property (p_slot) else $error("phase rotation broken");

  property p_int_quiet;
    @(posedge SYS_CLK) disable iff (rst_act)
    take && tgt != TGT_EXT |=> $stable(EXT_ADDR_LINES) && EXT_RW && !EXT_DATA_LINES_OE;
  endproperty
  a_int_quiet: assert property (p_int_quiet) else $error("internal access on bus");

  property p_ext_cycle;
    @(posedge SYS_CLK) disable iff (rst_act)
    s_ext_take |=> s_ext_strobe ##1
      (EXT_E_N && RSP_VALID && RSP_RDATA == $past(EXT_DATA_LINES_I));
  endproperty
  a_ext_cycle: assert property (p_ext_cycle) else $error("access not in one period");

  property p_setup;
    @(posedge SYS_CLK) disable iff (rst_act)
    s_ext_take |=> EXT_ADDR_LINES == $past(REQ_ADDR) ##1
      (!EXT_E_N && $stable(EXT_ADDR_LINES) && $stable(EXT_RW));
  endproperty
  a_setup: assert property (p_setup) else $error("address moved in strobe");

  property p_wdata;
    @(posedge SYS_CLK) disable iff (rst_act)
    s_ext_take and REQ_WRITE |=> !EXT_RW && EXT_DATA_LINES_OE
      && EXT_DATA_LINES_O == $past(REQ_WDATA);
  endproperty
  a_wdata: assert property (p_wdata) else $error("write data not driven");

  property p_rst_pins;
    @(posedge SYS_CLK) disable iff (1'b0)
    $past(rst_act) |-> EXT_ADDR_LINES == 16'hFFFF && EXT_E_N && !EXT_RW
      && EXT_DATA_LINES_OE && !RSP_VALID;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("reset pin state wrong");

  property p_boot;
    @(posedge SYS_CLK) disable iff (rst_act)
    st_ff == ST_BOOT && !e_n_ff |=> EXT_ADDR_LINES == 16'h0001 && EXT_RW ##2 st_ff == ST_CLEAR;
  endproperty
  a_boot: assert property (p_boot) else $error("boot fetch not at one");

  property p_clear;
    @(posedge SYS_CLK) disable iff (rst_act)
    st_ff == ST_CLEAR |=> ram_ff[$past(clr_ff)] == 8'h00
      && REQ_READY == ($past(clr_ff) == RAM_LAST);
  endproperty
  a_clear: assert property (p_clear) else $error("RAM byte not cleared");
endmodule

// *** pkg/emmi_defs.svh ***
// Constants of the memory map and external bus block
`ifndef EMMI_DEFS_SVH
`define EMMI_DEFS_SVH
`define EMMI_CLK_MHZ    20
`define EMMI_NCPU       3
`define EMMI_INT_BASE   16'hE800
`define EMMI_RAM_BYTES  2048
`define EMMI_NV_BASE    16'hF000
`define EMMI_NV_END     16'hF200
`define EMMI_NV_BYTES   512
`define EMMI_NV_AW      9
`define EMMI_ID_BYTES   8
`define EMMI_CKSUM_END  9'h0FF
`define EMMI_SEG_BYTES  2
`define EMMI_NV_WR_US   20
`define EMMI_BOOT_ADDR  16'h0001
`define EMMI_RST_ADDR   16'hFFFF
`endif

// *** pkg/emmi_pkg.sv ***
// Types shared by the memory map and external bus block
package emmi_pkg;
  typedef enum logic [5:0] {
    ST_BOOT  = 6'h01,
    ST_BACC  = 6'h02,
    ST_CLEAR = 6'h04,
    ST_IDLE  = 6'h08,
    ST_ACC   = 6'h10,
    ST_NVW   = 6'h20
  } emmi_state_t;
  typedef enum logic [1:0] {
    TGT_EXT = 2'h0,
    TGT_RAM = 2'h1,
    TGT_NV  = 2'h2,
    TGT_IO  = 2'h3
  } emmi_tgt_t;
endpackage

// *** pkg/emmi_nv_if.sv ***
// Carrier between the access sequencer and the nonvolatile store
`timescale 1ns/1ns
interface emmi_nv_if;
  logic       req;
  logic       we;
  logic [8:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       done;
  logic       lock_we;
  logic       lock_val;
  logic       lock_state;
  logic [7:0] alloc_len;
  logic [8:0] alloc_round;
  modport ctl (output req, we, addr, wdata, lock_we, lock_val, alloc_len,
               input rdata, done, lock_state, alloc_round);
  modport mem (input req, we, addr, wdata, lock_we, lock_val, alloc_len,
               output rdata, done, lock_state, alloc_round);
endinterface

// *** logic/emmi_nvs.sv ***
// Internal nonvolatile store with identity bytes, write skip and lock
`timescale 1ns/1ns
`include "emmi_defs.svh"
module emmi_nvs #(
  parameter int          NV_BYTES    = `EMMI_NV_BYTES,
  parameter int          SEG_BYTES   = `EMMI_SEG_BYTES,
  parameter int          WR_CYC      = `EMMI_NV_WR_US * `EMMI_CLK_MHZ,
  // Arbitrary identity values
  parameter logic [47:0] NODE_SERIAL = 48'h0123_4567_89AB,
  parameter logic [15:0] MAKER_CODE  = 16'h5A5A
) (
  input wire logic clk,
  input wire logic rst,
  emmi_nv_if.mem   nv
);
  logic [7:0]  mem_ff [NV_BYTES];
  logic [63:0] id_word;
  logic [7:0]  id_byte [`EMMI_ID_BYTES];
  logic [11:0] cnt_ff;
  logic        busy_ff;
  logic        done_ff;
  logic [7:0]  rdata_ff;
  logic        lock_ff;
  logic [8:0]  round_ff;
  logic [8:0]  waddr_ff;
  logic [7:0]  wdata_ff;
  logic        is_id;
  logic        locked;
  logic        same;

  assign id_word = {MAKER_CODE, NODE_SERIAL};
  genvar g;
  for (g = 0; g < `EMMI_ID_BYTES; g++) begin : g_id
    assign id_byte[g] = id_word[8*g +: 8];
  end

  assign is_id  = nv.addr < 9'(`EMMI_ID_BYTES);
  assign locked = lock_ff && (nv.addr <= `EMMI_CKSUM_END);
  assign same   = mem_ff[nv.addr] == nv.wdata;

  //==========================================
  // Access and timed write
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_ff  <= 1'b0;
      done_ff  <= 1'b0;
      cnt_ff   <= 12'h000;
      rdata_ff <= 8'h00;
      waddr_ff <= 9'h000;
      wdata_ff <= 8'h00;
    end else begin
      done_ff <= 1'b0;
      if (busy_ff) begin
        cnt_ff <= cnt_ff - 12'h001;
        if (cnt_ff == 12'h001) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end else if (nv.req && !nv.we) begin
        rdata_ff <= is_id ? id_byte[nv.addr[2:0]] : mem_ff[nv.addr];
        done_ff  <= 1'b1;
      end else if (nv.req) begin
        if (is_id || locked || same) begin
          done_ff <= 1'b1;
        end else begin
          busy_ff  <= 1'b1;
          cnt_ff   <= 12'(WR_CYC);
          waddr_ff <= nv.addr;
          wdata_ff <= nv.wdata;
        end
      end
    end
  end

  // Cell changes only once the write time has fully elapsed
  always_ff @(posedge clk) begin
    if (!rst && busy_ff && cnt_ff == 12'h001) begin
      mem_ff[waddr_ff] <= wdata_ff;
    end
  end

  //==========================================
  // Lock and segment rounding
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_ff  <= 1'b0;
      round_ff <= 9'h000;
    end else begin
      if (nv.lock_we) begin
        lock_ff <= nv.lock_val;
      end
      round_ff <= 9'(((int'(nv.alloc_len) + SEG_BYTES - 1) / SEG_BYTES) * SEG_BYTES);
    end
  end

  assign nv.rdata       = rdata_ff;
  assign nv.done        = done_ff;
  assign nv.lock_state  = lock_ff;
  assign nv.alloc_round = round_ff;

  //==========================================
  // Checks
  property p_id_prot;
    @(posedge clk) disable iff (rst)
    nv.req && nv.we && is_id && !busy_ff |=> done_ff && !busy_ff;
  endproperty
  a_id_prot: assert property (p_id_prot) else $error("identity byte written");

  property p_skip;
    @(posedge clk) disable iff (rst)
    nv.req && nv.we && same && !busy_ff |=> done_ff && !busy_ff;
  endproperty
  a_skip: assert property (p_skip) else $error("equal byte not skipped");

  property p_lock;
    @(posedge clk) disable iff (rst)
    nv.req && nv.we && locked && !busy_ff |=> !busy_ff;
  endproperty
  a_lock: assert property (p_lock) else $error("locked region written");

  property p_wr;
    @(posedge clk) disable iff (rst)
    nv.req && nv.we && !busy_ff && !is_id && !locked && !same |=> busy_ff && !done_ff;
  endproperty
  a_wr: assert property (p_wr) else $error("write cycle not started");

  property p_abort;
    @(posedge clk) disable iff (1'b0)
    rst |=> !busy_ff && !done_ff;
  endproperty
  a_abort: assert property (p_abort) else $error("write survives reset");

  property p_round;
    @(posedge clk) disable iff (rst)
    1'b1 |=> (round_ff >= 9'($past(nv.alloc_len))) &&
             (round_ff < 9'($past(nv.alloc_len)) + 9'(SEG_BYTES)) &&
             (round_ff % 9'(SEG_BYTES) == 9'h000);
  endproperty
  a_round: assert property (p_round) else $error("bad segment rounding");
endmodule

// *** verification/emmi_ext_mem.sv ***
// Behavioural external memory hanging on the enable-strobe bus
`timescale 1ns/1ns
module emmi_ext_mem #(
  parameter int         ACC_NS = 5,
  parameter logic [7:0] FILL   = 8'h5A
) (
  input  wire logic        clk,
  input  wire logic [15:0] addr,
  input  wire logic        e_n,
  input  wire logic        rw,
  input  wire logic [7:0]  bus,
  output logic [7:0]       q
);
  // ==========================================================
  // Storage
  logic [7:0] mem [0:65535];
  logic [7:0] last_ff;
  logic       rd_en;

  // Whole space is populated, so every region is a 256-byte multiple
  // and the low 16K firmware area is present
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[7:0] ^ FILL;
    end
  end

  // ==========================================================
  // Bus response
  always @(posedge clk) begin
    last_ff <= bus;
    if (!e_n && !rw) begin
      mem[addr] <= bus;
    end
  end

  assign rd_en = !e_n && rw;
  // Slow part: data lands late in the strobe phase; released bus
  // shows the inverse of its last level, never a stale copy
  assign #(ACC_NS) q = rd_en ? mem[addr] : ~last_ff;
endmodule

// *** verification/emmi_top_test.sv ***
// Self-checking bench for the memory map and external bus block
`timescale 1ns/1ns
module emmi_top_test;
  // ==========================================================
  // Signals
  localparam int         DLY   = 1;
  localparam int         NV_US = 1;
  localparam int         LIMIT = 20000;
  localparam logic [7:0] FILL  = 8'h5A;

  logic        sys_clk;
  logic        nrst;
  logic        low_supply;
  logic        req_valid;
  logic        req_write;
  logic        lock_we;
  logic        lock_val;
  logic [1:0]  req_cpu;
  logic [15:0] req_addr;
  logic [7:0]  req_wdata;
  logic [7:0]  alloc_len;
  logic        req_ready;
  logic        rsp_valid;
  logic [7:0]  rsp_rdata;
  logic [1:0]  slot_cpu;
  logic        init_done;
  logic [7:0]  boot_byte;
  logic        lock_state;
  logic [8:0]  alloc_round;
  logic [15:0] ext_addr_lines;
  logic [7:0]  data_i;
  logic [7:0]  data_o;
  logic        data_oe;
  logic        ext_e_n;
  logic        ext_rw;
  logic [7:0]  mem_q;
  int          fail_count;
  int          cmp_count;
  int          cycles;

  emmi_top #(.NV_WR_US(NV_US)) u_dut (
    .SYS_CLK(sys_clk), .NRST(nrst), .LOW_SUPPLY(low_supply),
    .REQ_VALID(req_valid), .REQ_CPU(req_cpu), .REQ_ADDR(req_addr),
    .REQ_WRITE(req_write), .REQ_WDATA(req_wdata), .REQ_READY(req_ready),
    .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .SLOT_CPU(slot_cpu),
    .INIT_DONE(init_done), .BOOT_BYTE(boot_byte), .LOCK_WE(lock_we),
    .LOCK_VAL(lock_val), .LOCK_STATE(lock_state), .ALLOC_LEN(alloc_len),
    .ALLOC_ROUND(alloc_round), .EXT_ADDR_LINES(ext_addr_lines),
    .EXT_DATA_LINES_I(data_i), .EXT_DATA_LINES_O(data_o),
    .EXT_DATA_LINES_OE(data_oe), .EXT_E_N(ext_e_n), .EXT_RW(ext_rw));

  emmi_ext_mem #(.ACC_NS(35), .FILL(FILL)) u_mem (
    .clk(sys_clk), .addr(ext_addr_lines), .e_n(ext_e_n), .rw(ext_rw),
    .bus(data_i), .q(mem_q));

  assign data_i = data_oe ? data_o : mem_q;

  // 20 MHz input clock, a supported rate
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Common tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Entered just after an edge; returns edges from take to answer
  task automatic access(input logic [1:0] cpu, input logic [15:0] addr, input logic wr,
                        input logic [7:0] wd, output logic [7:0] rd, output int lat);
    req_cpu = cpu;
    req_addr = addr;
    req_write = wr;
    req_wdata = wd;
    req_valid = 1'b1;
    while (!(req_ready === 1'b1 && ext_e_n === 1'b0 && slot_cpu === cpu)) begin
      @(posedge sys_clk);
      #DLY;
    end
    @(posedge sys_clk);
    #DLY;
    req_valid = 1'b0;
    lat = 0;
    while (rsp_valid !== 1'b1 && lat < 500) begin
      @(posedge sys_clk);
      #DLY;
      lat++;
    end
    rd = rsp_rdata;
  endtask

  task automatic set_lock(input logic v);
    lock_we = 1'b1;
    lock_val = v;
    @(posedge sys_clk);
    #DLY;
    lock_we = 1'b0;
    @(posedge sys_clk);
    #DLY;
    check(lock_state, v);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset(input bit by_supply);
    int n;
    if (by_supply) low_supply = 1'b1;
    else nrst = 1'b0;
    repeat (8) @(posedge sys_clk);
    #DLY;
    check(ext_addr_lines, 16'hFFFF);
    check(ext_e_n, 1'b1);
    check(ext_rw, 1'b0);
    check(data_oe, 1'b1);
    check(init_done, 1'b0);
    nrst = 1'b1;
    low_supply = 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      #DLY;
      n++;
    end while (ext_e_n !== 1'b0 && n < 4);
    // Boot address goes out at the first edge that sees the strobe low
    @(posedge sys_clk);
    #DLY;
    check(ext_addr_lines, 16'h0001);
    check(ext_rw, 1'b1);
    n = 0;
    while (init_done !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      #DLY;
      n++;
    end
    check(n >= 2048, 1'b1);
    check(boot_byte, 8'h01 ^ FILL);
    check(req_ready, 1'b1);
  endtask

  task automatic t_strobe();
    logic       prev_e;
    logic [1:0] prev_s;
    int         chg;
    chg = 0;
    for (int k = 0; k < 6; k++) begin
      prev_e = ext_e_n;
      prev_s = slot_cpu;
      @(posedge sys_clk);
      #DLY;
      check(ext_e_n, !prev_e);
      if (slot_cpu !== prev_s) begin
        chg++;
        check(slot_cpu, (prev_s == 2'd2) ? 2'd0 : prev_s + 2'd1);
      end
    end
    check(16'(chg), 16'd3);
  endtask

  task automatic t_ext();
    logic [7:0] rd;
    int         lat;
    access(2'd0, 16'h1234, 1'b1, 8'hC3, rd, lat);
    check(16'(lat), 16'd2);
    check(u_mem.mem[16'h1234], 8'hC3);
    access(2'd1, 16'h1234, 1'b0, 8'h00, rd, lat);
    check(rd, 8'hC3);
    check(16'(lat), 16'd2);
    access(2'd2, 16'hE7FF, 1'b0, 8'h00, rd, lat);
    check(rd, 8'hFF ^ FILL);
    access(2'd0, 16'hE800, 1'b1, 8'h77, rd, lat);
    check(u_mem.mem[16'hE800], 8'h00 ^ FILL);
    access(2'd1, 16'hE800, 1'b0, 8'h00, rd, lat);
    check(rd, 8'h77);
    access(2'd2, 16'hE801, 1'b0, 8'h00, rd, lat);
    check(rd, 8'h00);
  endtask

  task automatic t_nv();
    logic [7:0] rd;
    int         lat;
    // Refused or skipped writes answer as fast as reads
    access(2'd0, 16'hF000, 1'b1, 8'h00, rd, lat);
    check(16'(lat), 16'd2);
    access(2'd1, 16'hF000, 1'b0, 8'h00, rd, lat);
    check(rd, 8'hAB);
    access(2'd2, 16'hF007, 1'b0, 8'h00, rd, lat);
    check(rd, 8'h5A);
    access(2'd0, 16'hF120, 1'b1, 8'h3C, rd, lat);
    check(16'(lat), 16'(20 * NV_US + 2));
    access(2'd1, 16'hF120, 1'b1, 8'h3C, rd, lat);
    check(16'(lat), 16'd2);
    access(2'd2, 16'hF120, 1'b0, 8'h00, rd, lat);
    check(rd, 8'h3C);
  endtask

  task automatic t_lock();
    logic [7:0] rd;
    int         lat;
    access(2'd0, 16'hF080, 1'b1, 8'h11, rd, lat);
    check(16'(lat), 16'(20 * NV_US + 2));
    set_lock(1'b1);
    access(2'd1, 16'hF080, 1'b1, 8'h55, rd, lat);
    check(16'(lat), 16'd2);
    access(2'd2, 16'hF080, 1'b0, 8'h00, rd, lat);
    check(rd, 8'h11);
    access(2'd0, 16'hF150, 1'b1, 8'h66, rd, lat);
    check(16'(lat), 16'(20 * NV_US + 2));
    set_lock(1'b0);
    access(2'd1, 16'hF080, 1'b1, 8'h55, rd, lat);
    check(16'(lat), 16'(20 * NV_US + 2));
  endtask

  task automatic t_alloc();
    logic [7:0] lens [4];
    lens = '{8'd0, 8'd1, 8'd9, 8'd255};
    for (int k = 0; k < 4; k++) begin
      alloc_len = lens[k];
      repeat (2) @(posedge sys_clk);
      #DLY;
      check(alloc_round, {1'b0, lens[k]} + lens[k][0]);
    end
  endtask

  task automatic t_supply();
    logic [7:0] rd;
    int         lat;
    access(2'd0, 16'hF1A0, 1'b1, 8'h99, rd, lat);
    t_reset(1'b1);
    access(2'd1, 16'hF1A0, 1'b0, 8'h00, rd, lat);
    check(rd, 8'h99);
    access(2'd2, 16'hE800, 1'b0, 8'h00, rd, lat);
    check(rd, 8'h00);
  endtask

  // ==========================================================
  // Hang guard and main sequence
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial begin
    nrst = 1'b0;
    low_supply = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_cpu = 2'd0;
    req_addr = 16'h0000;
    req_wdata = 8'h00;
    lock_we = 1'b0;
    lock_val = 1'b0;
    alloc_len = 8'h00;
    fail_count = 0;
    cmp_count = 0;
    cycles = 0;
    t_reset(1'b0);
    t_strobe();
    t_ext();
    t_nv();
    t_lock();
    t_alloc();
    t_supply();
    tally_and_finish();
  end
endmodule
